// ---- inc/rxdc_pkg.sv ----
// constants and types for the receive dma request, coalescing and poll block
package rxdc_pkg;
    // ==========================================================
    // clock and timing
    localparam int RXDC_CLK_NS        = 20;
    localparam int RXDC_WAIT_STEP_NS  = 64;
    localparam int RXDC_POLL_STEP_NS  = 320;
    localparam int RXDC_POLL_STEP_CYC = RXDC_POLL_STEP_NS / RXDC_CLK_NS;
    localparam logic [8:0] RXDC_POLL_MAX_UNITS = 9'h100;
    // ==========================================================
    // register offsets
    localparam logic [7:0] RXDC_OFS_INTCTRL  = 8'h28;
    localparam logic [7:0] RXDC_OFS_BURST    = 8'h40;
    localparam logic [7:0] RXDC_OFS_POLL     = 8'h44;
    localparam logic [7:0] RXDC_OFS_FLAGS    = 8'h48;
    // ==========================================================
    // field positions and limits
    localparam int RXDC_FRAME_LSB  = 0;
    localparam int RXDC_PRIO_LSB   = 10;
    localparam int RXDC_WAIT_LSB   = 16;
    localparam int RXDC_FLAG_DONE  = 0;
    localparam int RXDC_FLAG_PRIO  = 1;
    localparam int RXDC_BURST_SHIFT = 5;
    localparam logic [7:0] RXDC_BURST_MIN = 8'h08;
    localparam logic [7:0] RXDC_FRAME_MIN = 8'h01;
    localparam logic [31:0] RXDC_INTCTRL_MASK = 32'hffff_1cff;
    // ==========================================================
    // reset values
    localparam logic [31:0] RXDC_INTCTRL_RST = 32'h0000_0000;
    localparam logic [7:0]  RXDC_BURST_RST   = 8'h08;
    localparam logic [7:0]  RXDC_POLL_RST    = 8'h01;
    // ==========================================================
    // descriptor poll states
    typedef enum logic [2:0] {
        RXDC_POLL_IDLE = 3'b001,
        RXDC_POLL_READ = 3'b010,
        RXDC_POLL_WAIT = 3'b100
    } rxdc_poll_e;
endpackage

// ---- inc/rxdc_coal_if.sv ----
// link between register side and the interrupt coalescer
`timescale 1ns/1ps
`default_nettype none
interface rxdc_coal_if;
    logic        done;
    logic [7:0]  frame_lim;
    logic [15:0] wait_lim;
    logic        fire;
    modport ctrl (output done, output frame_lim, output wait_lim, input fire);
    modport coal (input done, input frame_lim, input wait_lim, output fire);
endinterface
`default_nettype wire

// ---- verilog/rxdc_coalesce.sv ----
// receive completion coalescer: frame count or wait time, whichever first
`timescale 1ns/1ps
`default_nettype none
module rxdc_coalesce #(
    parameter int WAIT_STEP_NS = rxdc_pkg::RXDC_WAIT_STEP_NS
) (
    input  wire logic  clk_sys,
    input  wire logic  reset,
    rxdc_coal_if.coal  cif
);
    import rxdc_pkg::*;

    logic [7:0]  frames_q;
    logic [21:0] cnt_q;
    logic        pending_q;
    logic [7:0]  frame_eff;
    logic [27:0] wait_prod;
    logic [21:0] wait_cyc;
    logic        frame_hit;
    logic        time_hit;

    // ==========================================================
    // limits
    // zero frame limit means one
    assign frame_eff = (cif.frame_lim == 8'h00) ? RXDC_FRAME_MIN : cif.frame_lim;
    // wait bound in 64 ns steps
    assign wait_prod = 28'(cif.wait_lim) * 28'(WAIT_STEP_NS);
    assign wait_cyc  = 22'(wait_prod / 28'(RXDC_CLK_NS));

    // ==========================================================
    // fire decision
    // first of count or time
    assign frame_hit = cif.done && ({1'b0, frames_q} + 9'h001 >= {1'b0, frame_eff});
    assign time_hit  = (cif.done && cif.wait_lim == 16'h0000)
                    || (pending_q && (cnt_q + 22'h000001 >= wait_cyc));
    // fire on a frame count hit or a wait time hit, not on every completion
    assign cif.fire  = frame_hit || time_hit;

    // ==========================================================
    // counters
    // restart on fire
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            frames_q  <= 8'h00;
            cnt_q     <= 22'h000000;
            pending_q <= 1'b0;
        end else if (cif.fire) begin
            frames_q  <= 8'h00;
            cnt_q     <= 22'h000000;
            pending_q <= 1'b0;
        end else begin
            if (cif.done) begin
                frames_q  <= frames_q + 8'h01;
                pending_q <= 1'b1;
            end
            if (pending_q) begin
                cnt_q <= cnt_q + 22'h000001;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_first_done_step1;
        cif.done && !pending_q && cif.wait_lim == 16'h0001 && frame_eff > 8'h01;
    endsequence

    a_wait_zero_now: assert property (cif.done && cif.wait_lim == 16'h0000 |-> cif.fire)
        else $error("zero wait did not fire at once");
    a_frame_zero_one: assert property (cif.done && cif.frame_lim == 8'h00 |-> cif.fire)
        else $error("zero frame limit did not fire per transfer");
    a_fire_restarts: assert property (cif.fire |=> frames_q == 8'h00 && !pending_q)
        else $error("coalescer not restarted after fire");
    a_wait_one_step: assert property (s_first_done_step1 |-> ##[1:3] cif.fire)
        else $error("one wait step did not fire in time");
    a_done_not_lost: assert property (pending_q && cif.wait_lim <= 16'h0010
                                      |-> ##[0:51] cif.fire)
        else $error("completion never signalled");
    a_count_fire: assert property (pending_q && cif.done && frames_q + 8'h01 == frame_eff
                                   |-> cif.fire)
        else $error("frame count reached without fire");
endmodule
`default_nettype wire

// ---- verilog/rxdc_top.sv ----
// receive dma request level, interrupt coalescing, priority flag and descriptor polling
`timescale 1ns/1ps
`default_nettype none
module rxdc_top #(
    parameter int WAIT_STEP_NS = rxdc_pkg::RXDC_WAIT_STEP_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata_q,
    input  wire logic [13:0] fifo_used_bytes,
    input  wire logic        frag_valid,
    input  wire logic [15:0] fragment_length,
    output logic             rx_dma_req,
    input  wire logic        xfer_done,
    input  wire logic        tag_valid,
    input  wire logic [2:0]  tag_priority,
    output logic             rx_transfer_done_flag,
    output logic             rx_high_priority_flag,
    input  wire logic        desc_fetch,
    output logic             desc_read_req,
    input  wire logic        desc_read_ack,
    input  wire logic [39:0] next_descriptor_link,
    output logic             desc_link_ready_q,
    output logic             polling_active
);
    import rxdc_pkg::*;

    logic [31:0] intctrl_q;
    logic [7:0]  burst_q;
    logic [7:0]  poll_q;
    logic        done_flag_q;
    logic        prio_flag_q;
    rxdc_poll_e  state_q;
    rxdc_poll_e  state_d;
    logic [12:0] poll_cnt_q;
    logic [8:0]  poll_units;
    logic [12:0] poll_cyc;
    logic [7:0]  thresh_eff;
    logic [13:0] thresh_bytes;
    logic        prio_hit;
    logic        flag_clr_done;
    logic        flag_clr_prio;

    rxdc_coal_if cif ();

    // ==========================================================
    // register writes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            intctrl_q <= RXDC_INTCTRL_RST;
            burst_q   <= RXDC_BURST_RST;
            poll_q    <= RXDC_POLL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                RXDC_OFS_INTCTRL: intctrl_q <= reg_wdata & RXDC_INTCTRL_MASK;
                RXDC_OFS_BURST:   burst_q   <= reg_wdata[7:0];
                RXDC_OFS_POLL:    poll_q    <= reg_wdata[7:0];
                default:          intctrl_q <= intctrl_q;
            endcase
        end
    end

    // ==========================================================
    // register reads
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                RXDC_OFS_INTCTRL: reg_rdata_q <= intctrl_q;
                RXDC_OFS_BURST:   reg_rdata_q <= {24'h000000, burst_q};
                RXDC_OFS_POLL:    reg_rdata_q <= {24'h000000, poll_q};
                RXDC_OFS_FLAGS:   reg_rdata_q <= {30'h00000000, prio_flag_q, done_flag_q};
                default:          reg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // bus master request
    // clamp threshold to minimum
    assign thresh_eff   = (burst_q < RXDC_BURST_MIN) ? RXDC_BURST_MIN : burst_q;
    assign thresh_bytes = {1'b0, thresh_eff, 5'h00} << (RXDC_BURST_SHIFT - 5);
    // fill above threshold, fill above fragment
    assign rx_dma_req   = (fifo_used_bytes > thresh_bytes)
                       || (frag_valid && {2'b00, fifo_used_bytes} > fragment_length);

    // ==========================================================
    // coalescer
    assign cif.done      = xfer_done;
    assign cif.frame_lim = intctrl_q[RXDC_FRAME_LSB +: 8];
    assign cif.wait_lim  = intctrl_q[RXDC_WAIT_LSB +: 16];

    rxdc_coalesce #(
        .WAIT_STEP_NS (WAIT_STEP_NS)
    ) u_coalesce (
        .clk_sys (clk_sys),
        .reset   (reset),
        .cif     (cif.coal)
    );

    // ==========================================================
    // interrupt flags, write one to clear, set wins
    assign flag_clr_done = reg_wr && reg_addr == RXDC_OFS_FLAGS && reg_wdata[RXDC_FLAG_DONE];
    assign flag_clr_prio = reg_wr && reg_addr == RXDC_OFS_FLAGS && reg_wdata[RXDC_FLAG_PRIO];
    assign prio_hit = tag_valid && (tag_priority >= intctrl_q[RXDC_PRIO_LSB +: 3]);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            done_flag_q <= 1'b0;
        end else if (cif.fire) begin
            done_flag_q <= 1'b1;
        end else if (flag_clr_done) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prio_flag_q <= 1'b0;
        end else if (prio_hit) begin
            prio_flag_q <= 1'b1;
        end else if (flag_clr_prio) begin
            prio_flag_q <= 1'b0;
        end
    end

    assign rx_transfer_done_flag = done_flag_q;
    assign rx_high_priority_flag = prio_flag_q;

    // ==========================================================
    // descriptor polling
    // zero interval taken as the maximum
    assign poll_units = (poll_q == 8'h00) ? RXDC_POLL_MAX_UNITS : {1'b0, poll_q};
    assign poll_cyc   = 13'({4'h0, poll_units} * 13'(RXDC_POLL_STEP_CYC));

    always_comb begin
        state_d = state_q;
        case (state_q)
            RXDC_POLL_IDLE: begin
                if (desc_fetch) begin
                    state_d = RXDC_POLL_READ;
                end
            end
            RXDC_POLL_READ: begin
                if (desc_read_ack) begin
                    state_d = (next_descriptor_link == 40'h00_0000_0000) ? RXDC_POLL_WAIT
                                                                       : RXDC_POLL_IDLE;
                end
            end
            RXDC_POLL_WAIT: begin
                if (poll_cnt_q + 13'h0001 >= poll_cyc) begin
                    state_d = RXDC_POLL_READ;
                end
            end
            default: state_d = RXDC_POLL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= RXDC_POLL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            poll_cnt_q <= 13'h0000;
        end else if (state_q == RXDC_POLL_WAIT && state_d == RXDC_POLL_WAIT) begin
            poll_cnt_q <= poll_cnt_q + 13'h0001;
        end else begin
            poll_cnt_q <= 13'h0000;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            desc_link_ready_q <= 1'b0;
        end else begin
            desc_link_ready_q <= state_q == RXDC_POLL_READ && desc_read_ack
                              && next_descriptor_link != 40'h00_0000_0000;
        end
    end

    assign desc_read_req  = (state_q == RXDC_POLL_READ);
    assign polling_active = (state_q == RXDC_POLL_WAIT);

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_zero_link_read;
        state_q == RXDC_POLL_READ && desc_read_ack
            && next_descriptor_link == 40'h00_0000_0000 && poll_q == 8'h01 && !reg_wr;
    endsequence

    a_req_low_fill: assert property (fifo_used_bytes <= 14'd256 && !frag_valid
                                     |-> !rx_dma_req)
        else $error("request below minimum burst level");
    a_req_above_level: assert property (burst_q >= 8'h08 && !frag_valid
                                        && {1'b0, fifo_used_bytes} > {2'b00, burst_q, 5'h00}
                                        |-> rx_dma_req)
        else $error("no request above burst level");
    a_req_unit_size: assert property (burst_q == 8'h10 && !frag_valid
                                      && fifo_used_bytes == 14'd512 |-> !rx_dma_req)
        else $error("burst level unit is not 32 bytes");
    a_req_fragment: assert property (frag_valid && {2'b00, fifo_used_bytes} > fragment_length
                                     |-> rx_dma_req)
        else $error("no request above fragment length");
    a_done_flag_set: assert property (cif.fire |=> rx_transfer_done_flag)
        else $error("completion flag not set");
    a_prio_flag_set: assert property (prio_hit |=> rx_high_priority_flag)
        else $error("priority flag not set");
    a_prio_flag_hold: assert property (!rx_high_priority_flag && !prio_hit
                                       |=> !rx_high_priority_flag)
        else $error("priority flag set without a high tag");
    a_zero_link_poll: assert property (s_zero_link_read |=> polling_active)
        else $error("zero link did not enter polling");
    a_poll_period: assert property (s_zero_link_read |=> polling_active ##15
                                    (polling_active && poll_cnt_q == 13'h000f)
                                    ##1 desc_read_req)
        else $error("poll period of one unit not 16 cycles");
endmodule
`default_nettype wire

// ---- test/rxdc_desc_mem.sv ----
// descriptor memory model answering receive descriptor reads
`timescale 1ns/1ps
`default_nettype none
module rxdc_desc_mem (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        desc_read_req,
    input  wire logic [3:0]  lat,
    input  wire logic [39:0] link_val,
    output logic             desc_read_ack,
    output logic      [39:0] next_descriptor_link
);
    logic [3:0] cnt_q;
    // ==========================================================
    // read answer after lat cycles, link scrambled outside ack
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            desc_read_ack <= 1'h0;
            next_descriptor_link <= 40'h0;
        end else begin
            desc_read_ack <= 1'h0;
            next_descriptor_link <= ~next_descriptor_link;
            if (desc_read_req && !desc_read_ack) begin
                if (cnt_q == lat) begin
                    desc_read_ack <= 1'h1;
                    next_descriptor_link <= link_val;
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the receive dma control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rxdc_pkg::*;
    logic        clk_sys;
    logic        reset;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata_q;
    logic [13:0] fifo_used_bytes;
    logic        frag_valid;
    logic [15:0] fragment_length;
    logic        rx_dma_req;
    logic        xfer_done;
    logic        tag_valid;
    logic [2:0]  tag_priority;
    logic        rx_transfer_done_flag;
    logic        rx_high_priority_flag;
    logic        desc_fetch;
    logic        desc_read_req;
    logic        desc_read_ack;
    logic [39:0] next_descriptor_link;
    logic        desc_link_ready_q;
    logic        polling_active;
    logic [3:0]  lat;
    logic [39:0] link_val;
    int          n_mismatch;
    int          samples_checked;
    rxdc_top #(.WAIT_STEP_NS(20)) rxdc_top_i (.clk_sys(clk_sys), .reset(reset),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .fifo_used_bytes(fifo_used_bytes), .frag_valid(frag_valid),
        .fragment_length(fragment_length), .rx_dma_req(rx_dma_req), .xfer_done(xfer_done),
        .tag_valid(tag_valid), .tag_priority(tag_priority),
        .rx_transfer_done_flag(rx_transfer_done_flag),
        .rx_high_priority_flag(rx_high_priority_flag), .desc_fetch(desc_fetch),
        .desc_read_req(desc_read_req), .desc_read_ack(desc_read_ack),
        .next_descriptor_link(next_descriptor_link), .desc_link_ready_q(desc_link_ready_q),
        .polling_active(polling_active));
    rxdc_desc_mem rxdc_desc_mem_i (.clk_sys(clk_sys), .reset(reset),
        .desc_read_req(desc_read_req), .lat(lat), .link_val(link_val),
        .desc_read_ack(desc_read_ack), .next_descriptor_link(next_descriptor_link));
    // ==========================================================
    // clock and watchdog
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #(20 * 30000);
        n_mismatch++;
        give_verdict();
    end
    // ==========================================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chkb(input string nm, input logic seen, input logic exp);
        chk(nm, {39'h0, seen}, {39'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
        @(negedge clk_sys);
        reg_wr = 1'h0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'h1, a};
        @(negedge clk_sys);
        reg_rd = 1'h0;
        chk(nm, {8'h0, reg_rdata_q}, {8'h0, exp});
    endtask
    task automatic pulse_xfer;
        @(negedge clk_sys);
        xfer_done = 1'h1;
        @(negedge clk_sys);
        xfer_done = 1'h0;
    endtask
    // ==========================================================
    // coalescing cases: limit, restart, zero limit, zero wait, timed
    task automatic coal_test;
        int cn[6] = '{3, 3, 0, 255, 255, 255};
        int cw[6] = '{100, 100, 100, 0, 10, 1};
        int np[6] = '{3, 3, 1, 1, 1, 1};
        int dl[6] = '{0, 0, 0, 0, 10, 1};
        for (int i = 0; i < 6; i++) begin
            wr(8'h28, {16'(cw[i]), 8'h0, 8'(cn[i])});
            for (int k = 1; k < np[i]; k++) begin
                pulse_xfer();
                chkb("done_early", rx_transfer_done_flag, 1'h0);
            end
            pulse_xfer();
            for (int k = 0; k < dl[i]; k++) begin
                chkb("done_wait", rx_transfer_done_flag, 1'h0);
                @(negedge clk_sys);
            end
            chkb("done_set", rx_transfer_done_flag, 1'h1);
            rc(8'h48, 32'h1, "flags_done");
            wr(8'h48, 32'h1);
            chkb("done_clear", rx_transfer_done_flag, 1'h0);
        end
    endtask
    // ==========================================================
    // descriptor polling with zero link then valid link
    task automatic poll_test(input logic [7:0] p, input logic [3:0] l);
        int n;
        n = 0;
        wr(8'h44, {24'h0, p});
        lat = l;
        link_val = 40'h0;
        @(negedge clk_sys);
        desc_fetch = 1'h1;
        @(negedge clk_sys);
        desc_fetch = 1'h0;
        chkb("read_req", desc_read_req, 1'h1);
        while (polling_active !== 1'h1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chkb("polling", polling_active, 1'h1);
        link_val = 40'h12_3456_7800;
        n = 0;
        while (polling_active === 1'h1 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("poll_cycles", 40'(n), 40'(p * 16));
        chkb("reread_req", desc_read_req, 1'h1);
        n = 0;
        while (desc_link_ready_q !== 1'h1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chkb("link_ready", desc_link_ready_q, 1'h1);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        static logic [7:0] bt[4] = '{8'h03, 8'h08, 8'h10, 8'hff};
        int th;
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 8'h0, 32'h0};
        {fifo_used_bytes, frag_valid, fragment_length} = {14'h0, 1'h0, 16'h0};
        {xfer_done, tag_valid, tag_priority, desc_fetch} = {2'h0, 3'h0, 1'h0};
        {lat, link_val} = {4'h0, 40'h0};
        n_mismatch = 0;
        samples_checked = 0;
        repeat (20) @(negedge clk_sys);
        reset = 1'h0;
        rc(8'h28, 32'h0, "rst_ctrl");
        rc(8'h40, 32'h8, "rst_burst");
        rc(8'h44, 32'h1, "rst_poll");
        rc(8'h48, 32'h0, "rst_flags");
        wr(8'h28, 32'hffff_ffff);
        rc(8'h28, 32'hffff_1cff, "ctrl_mask");
        wr(8'h50, 32'h1234_5678);
        rc(8'h50, 32'h0, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h40, {24'h0, bt[i]});
            th = ((bt[i] < 8'h08) ? 8 : int'(bt[i])) * 32;
            fifo_used_bytes = 14'(th);
            @(negedge clk_sys);
            chkb("req_at_level", rx_dma_req, 1'h0);
            fifo_used_bytes = 14'(th + 1);
            @(negedge clk_sys);
            chkb("req_above", rx_dma_req, 1'h1);
        end
        {fifo_used_bytes, frag_valid, fragment_length} = {14'h64, 1'h1, 16'h64};
        @(negedge clk_sys);
        chkb("req_frag_eq", rx_dma_req, 1'h0);
        fifo_used_bytes = 14'h65;
        @(negedge clk_sys);
        chkb("req_frag_gt", rx_dma_req, 1'h1);
        frag_valid = 1'h0;
        @(negedge clk_sys);
        chkb("req_no_frag", rx_dma_req, 1'h0);
        $display("test request done");
        coal_test();
        $display("test coalescing done");
        wr(8'h28, 32'h0000_0cff);
        for (int p = 0; p < 8; p++) begin
            @(negedge clk_sys);
            {tag_valid, tag_priority} = {1'h1, 3'(p)};
            @(negedge clk_sys);
            tag_valid = 1'h0;
            chkb("prio_flag", rx_high_priority_flag, p >= 3);
            rc(8'h48, {30'h0, p >= 3, 1'h0}, "flags_prio");
            wr(8'h48, 32'h2);
        end
        $display("test priority done");
        poll_test(8'h02, 4'h0);
        poll_test(8'hff, 4'h5);
        poll_test(8'h01, 4'h2);
        $display("test polling done");
        give_verdict();
    end
endmodule
`default_nettype wire
